// *** agen_defines.vh ***
// Constants for the data address generator
`ifndef AGEN_DEFINES_VH
`define AGEN_DEFINES_VH
// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_XSRT 12'h004
`define OFF_XEND 12'h008
`define OFF_YSRT 12'h00C
`define OFF_YEND 12'h010
`define OFF_STAT 12'h014
// Control fields
`define XSEL_LO 0
`define XSEL_HI 3
`define YSEL_LO 4
`define YSEL_HI 7
`define YEN_BIT 14
`define XEN_BIT 15
`define SEL_OFF 4'hF
// Reset values
`define CTRL_RST 16'h00FF
`define BND_RST 16'h0000
// Addressing modes
`define M_FILE 3'h0
`define M_DIR 3'h1
`define M_IND 3'h2
`define M_POST 3'h3
`define M_PRE 3'h4
`define M_IDX 3'h5
`define M_LOFF 3'h6
// Instruction classes
`define C_MCU 2'h0
`define C_MOVE 2'h1
`define C_MAC 2'h2
`define C_FILE 2'h3
// Address spaces
`define S_XRD 2'h0
`define S_XWR 2'h1
`define S_Y 2'h2
// Literal kinds
`define L_5 3'h0
`define L_8 3'h1
`define L_10 3'h2
`define L_16 3'h3
`define L_BR 3'h4
`define L_HOLD 3'h5
// Multiply-accumulate pointers
`define MAC_X0 4'h8
`define MAC_X1 4'h9
`define MAC_Y0 4'hA
`define MAC_Y1 4'hB
`endif

// *** data_address_generator.v ***
// Effective-address generator with circular buffers and APB registers
//
// Notes on behaviour
// R1: file direct uses 13-bit near address
// R2: file results go to file or register 0
// R3: first source register direct; second reg/mem/literal
// R4: indirect uses pointer unchanged as address
// R5: post-modify: address is pointer, then step
// R6: pre-modify: step pointer, use new value
// R7: indexed: pointer plus offset register
// R8: literal offset: pointer plus instruction literal
// R9: move source/destination share offset field
// R10: move adds indexed, 8- and 16-bit literals
// R11: MAC pointers 8..11; 8,9 X, 10,11 Y
// R12: MAC indexed only via register 9 or 11
// R13: MAC: indirect, indexed, post by 2/4/6
// R14: branch signed 16-bit, hold unsigned 14-bit
// R15: one circular buffer in X, one in Y
// R16: software avoids stack registers as circular pointer
// R17: power-of-two buffers wrap both directions
// R18: 16-bit start/end registers per space
// R19: buffers up to 64 Kbytes
// R20: Y circular addresses keep bit 0 clear
// R21: select value 15 disables circular addressing
// R22: X select bits 3:0, enable bit 15
// R23: Y select bits 7:4, enable bit 14
// R24: boundary test beyond limit, not only equal
// R25: corrected pointer written back only when modifying
// R26: wrap by overshoot from the other boundary
`timescale 1ns/100ps
`include "agen_defines.vh"
module data_address_generator (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Request from the decoder
  input wire req_valid,
  input wire [1:0] req_class,
  input wire [2:0] req_mode,
  input wire [1:0] req_space,
  input wire [3:0] base_index,
  input wire [3:0] ptr_index,
  input wire [15:0] ptr_value,
  input wire [3:0] off_index,
  input wire [15:0] off_value,
  input wire [15:0] mod_amount,
  input wire [2:0] lit_kind,
  input wire [15:0] lit_raw,
  input wire [12:0] file_addr,
  input wire to_default,
  // Answer
  output reg ea_valid_r,
  output reg [15:0] ea_r,
  output reg [1:0] ea_space_r,
  output reg ea_error_r,
  output reg wb_en_r,
  output reg [3:0] wb_index_r,
  output reg [15:0] wb_value_r,
  output reg [3:0] src1_index_r,
  output reg [3:0] off_index_r,
  output reg [15:0] lit_value_r,
  output reg res_to_file_r,
  output reg [3:0] res_index_r
);

  // Registers
  // Bounds are byte addresses, end included
  // No alignment check: software keeps start and end sensible
  reg [15:0] ctrl_r; // circular_addr_control
  reg [15:0] x_circular_start_r; // X buffer first byte
  reg [15:0] x_circular_end_r; // X buffer last byte
  reg [15:0] y_circular_start_r; // Y buffer first byte
  reg [15:0] y_circular_end_r; // Y buffer last byte

  // Control fields
  // Decoded once, shared by status and the circular check
  wire [3:0] x_pointer_select = ctrl_r[`XSEL_HI:`XSEL_LO]; // R22
  wire [3:0] y_pointer_select = ctrl_r[`YSEL_HI:`YSEL_LO]; // R23
  wire x_circular_enable = ctrl_r[`XEN_BIT]; // R22
  wire y_circular_enable = ctrl_r[`YEN_BIT]; // R23

  // Circular check for one space; select 15 turns it off
  // One compare per space keeps the path short
  // The select field alone picks the pointer
  function circ_on;
    input en;
    input [3:0] sel;
    input [3:0] ptr;
    begin
      circ_on = en && (sel != `SEL_OFF) && (sel == ptr); // R21 R22 R23
    end
  endfunction

  // Wrap an address back inside [s,e]; length is 17 bits wide
  // Single correction only: a jump over more than one length
  // lands outside the buffer, so steps must stay below it
  // Direction comes from the sign of the step or offset
  function [15:0] mod_fix;
    input [15:0] a;
    input [15:0] s;
    input [15:0] e;
    input down;
    reg [16:0] len;
    reg [16:0] t;
    begin
      // Extra bit: a full-space buffer overflows 16 bits
      len = {1'b0, e} - {1'b0, s} + 17'h00001; // R18 R19
      t = {1'b0, a};
      if (!down && (a > e)) begin // R24 R26
        t = {1'b0, a} - len;
      end else if (down && (a < s)) begin // R24 R26
        t = {1'b0, a} + len;
      end
      mod_fix = t[15:0]; // R17
    end
  endfunction

  // APB: always ready, one word per register
  // Zero wait states: each access ends in its first access cycle
  // Only the low half of each word is stored
  assign pready = 1'b1;
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;

  // Address decode
  // Byte addresses; unmapped ones answer with an error
  wire hit_c = (paddr == `OFF_CTRL);
  wire hit_xs = (paddr == `OFF_XSRT);
  wire hit_xe = (paddr == `OFF_XEND);
  wire hit_ys = (paddr == `OFF_YSRT);
  wire hit_ye = (paddr == `OFF_YEND);
  wire hit_st = (paddr == `OFF_STAT);
  wire mapped = hit_c | hit_xs | hit_xe | hit_ys | hit_ye | hit_st;

  // Status bits shown to software
  // Status is read-only; writes to it are dropped
  reg last_err_r; // Error of last request
  reg [15:0] last_ea_r; // Last address produced
  wire x_armed = x_circular_enable && (x_pointer_select != `SEL_OFF);
  wire y_armed = y_circular_enable && (y_pointer_select != `SEL_OFF);

  // Read mux
  // Hits are one-hot, so the order of the items does not matter
  reg [31:0] rd_val;
  always @* begin
    case (1'b1)
      hit_c: rd_val = {16'h0000, ctrl_r};
      hit_xs: rd_val = {16'h0000, x_circular_start_r};
      hit_xe: rd_val = {16'h0000, x_circular_end_r};
      hit_ys: rd_val = {16'h0000, y_circular_start_r};
      hit_ye: rd_val = {16'h0000, y_circular_end_r};
      hit_st: rd_val = {last_ea_r, 13'h0000, last_err_r, y_armed, x_armed};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Register writes and registered read data
  // Read data is caught in setup so it stands through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Both selects start at 15: circular addressing off
      ctrl_r <= `CTRL_RST;
      x_circular_start_r <= `BND_RST;
      x_circular_end_r <= `BND_RST;
      y_circular_start_r <= `BND_RST;
      y_circular_end_r <= `BND_RST;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
        pslverr <= !mapped; // Unmapped: error answer
      end
      // Writes land at the access edge only
      if (wr_acc) begin
        if (hit_c) begin
          ctrl_r <= pwdata[15:0];
        end
        if (hit_xs) begin
          x_circular_start_r <= pwdata[15:0]; // R18
        end
        if (hit_xe) begin
          x_circular_end_r <= pwdata[15:0]; // R18
        end
        if (hit_ys) begin
          y_circular_start_r <= pwdata[15:0]; // R18
        end
        if (hit_ye) begin
          y_circular_end_r <= pwdata[15:0]; // R18
        end
      end
    end
  end

  // Address calculation
  // One combinational pass; the answer registers
  // break the path towards the memory address ports
  reg [1:0] sp; // Effective space
  reg err; // Illegal combination
  reg [15:0] delta; // Step or offset
  reg [15:0] raw; // Uncorrected sum
  reg [15:0] fixd; // Corrected sum
  reg [15:0] ea; // Effective address
  reg wb; // Pointer written back
  reg [15:0] wbv; // Value written back
  reg is_y; // Y space selected
  reg cx; // X circular applies
  reg cy; // Y circular applies
  reg [15:0] lit; // Formatted literal
  reg [15:0] mag; // Step magnitude
  always @* begin
    sp = req_space;
    err = 1'b0;
    delta = 16'h0000;
    mag = mod_amount[15] ? (16'h0000 - mod_amount) : mod_amount;
    // Space request ignored for MAC: the pointer decides
    // MAC pointers pick their own space
    if (req_class == `C_MAC) begin
      if (ptr_index == `MAC_X0 || ptr_index == `MAC_X1) begin
        sp = `S_XRD; // R11
      end else if (ptr_index == `MAC_Y0 || ptr_index == `MAC_Y1) begin
        sp = `S_Y; // R11
      end else begin
        err = 1'b1; // R11
      end
      case (req_mode)
        `M_IND: begin
          // Plain indirect: nothing more to refuse
          delta = 16'h0000; // R13
        end
        `M_POST: begin
          if (mag != 16'h0002 && mag != 16'h0004 && mag != 16'h0006) begin
            err = 1'b1; // R13
          end
        end
        `M_IDX: begin
          if (ptr_index != `MAC_X1 && ptr_index != `MAC_Y1) begin
            err = 1'b1; // R12
          end
        end
        default: err = 1'b1; // R13
      endcase
    end else if (req_class == `C_MCU) begin
      // MCU has no offset modes
      if (req_mode == `M_IDX || req_mode == `M_LOFF) begin
        err = 1'b1; // R10
      end
      // File direct is refused for MCU here; the move class still accepts it
      if (req_mode == `M_FILE) begin
        err = 1'b1;
      end
    end else if (req_class == `C_FILE) begin
      if (req_mode != `M_FILE && req_mode != `M_DIR) begin
        err = 1'b1; // R1
      end
    end
    // Step or offset by mode
    // Offsets are signed, so a negative one counts as down
    case (req_mode)
      `M_POST: delta = mod_amount; // R5
      `M_PRE: delta = mod_amount; // R6
      `M_IDX: delta = off_value; // R7 R9
      `M_LOFF: delta = lit_raw; // R8
      default: delta = 16'h0000; // R4
    endcase
    // Sum wraps at 16 bits, like the pointer itself
    raw = ptr_value + delta;
    is_y = (sp == `S_Y);
    cx = !is_y && circ_on(x_circular_enable, x_pointer_select, ptr_index); // R15
    cy = is_y && circ_on(y_circular_enable, y_pointer_select, ptr_index); // R15
    // X read and X write share one buffer
    if (cx) begin
      fixd = mod_fix(raw, x_circular_start_r, x_circular_end_r, delta[15]);
    end else if (cy) begin
      fixd = mod_fix(raw, y_circular_start_r, y_circular_end_r, delta[15]);
      fixd = {fixd[15:1], 1'b0}; // R20
    end else begin
      fixd = raw;
    end
    // Address and write-back by mode
    // Post mode writes back the stepped value, not the address used
    // Indexed and literal modes correct the address only
    wb = 1'b0;
    wbv = ptr_value;
    case (req_mode)
      `M_FILE: ea = {3'b000, file_addr}; // R1
      `M_DIR: ea = ptr_value;
      `M_IND: ea = (cy) ? {ptr_value[15:1], 1'b0} : ptr_value; // R4
      `M_POST: begin
        ea = (cy) ? {ptr_value[15:1], 1'b0} : ptr_value; // R5
        wb = 1'b1; // R5 R25
        wbv = fixd;
      end
      `M_PRE: begin
        ea = fixd; // R6
        wb = 1'b1; // R6 R25
        wbv = fixd;
      end
      `M_IDX: ea = fixd; // R7 R25
      `M_LOFF: ea = fixd; // R8 R25
      default: begin
        ea = 16'h0000;
        err = 1'b1;
      end
    endcase
    // Literal formats
    // Branch literal passes as is; its sign is for the user
    case (lit_kind)
      `L_5: lit = {11'h000, lit_raw[4:0]}; // R3
      `L_8: lit = {8'h00, lit_raw[7:0]}; // R10
      `L_10: lit = {6'h00, lit_raw[9:0]};
      `L_16: lit = lit_raw; // R10
      `L_BR: lit = lit_raw; // R14
      `L_HOLD: lit = {2'b00, lit_raw[13:0]}; // R14
      default: lit = 16'h0000;
    endcase
    // A refused request must never touch the pointer
    if (err) begin
      wb = 1'b0;
    end
  end

  // Answer registers, one cycle after the request
  // Strobes follow every cycle; data only on a taken request,
  // so the far side can read them until the next one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_valid_r <= 1'b0;
      ea_r <= 16'h0000;
      ea_space_r <= 2'h0;
      ea_error_r <= 1'b0;
      wb_en_r <= 1'b0;
      wb_index_r <= 4'h0;
      wb_value_r <= 16'h0000;
      src1_index_r <= 4'h0;
      off_index_r <= 4'h0;
      lit_value_r <= 16'h0000;
      res_to_file_r <= 1'b0;
      res_index_r <= 4'h0;
      last_err_r <= 1'b0;
      last_ea_r <= 16'h0000;
    end else if (ce) begin
      // Frozen with everything else while ce is low
      ea_valid_r <= req_valid;
      wb_en_r <= req_valid && wb;
      if (req_valid) begin
        ea_r <= ea;
        ea_space_r <= sp;
        ea_error_r <= err;
        wb_index_r <= ptr_index;
        wb_value_r <= wbv;
        src1_index_r <= base_index; // R3
        off_index_r <= off_index; // R9
        lit_value_r <= lit;
        // File results: back to file or register 0
        res_to_file_r <= (req_class == `C_FILE) && !to_default; // R2
        res_index_r <= (req_class == `C_FILE) ? 4'h0 : ptr_index; // R2
        last_err_r <= err;
        last_ea_r <= ea;
      end
    end
  end

endmodule // data_address_generator

// *** work_register_model.sv ***
// Working-register file on the far side
`timescale 1ns/100ps
module work_register_model (
  // Clock, reset
  input wire pclk,
  input wire presetn,
  // Reads
  input wire [3:0] ptr_index,
  input wire [3:0] off_index,
  output wire [15:0] ptr_value,
  output wire [15:0] off_value,
  // Write-back
  input wire wb_en_r,
  input wire [3:0] wb_index_r,
  input wire [15:0] wb_value_r
);
  reg [15:0] wregs [0:15]; // Loaded by the bench
  assign ptr_value = wregs[ptr_index];
  assign off_value = wregs[off_index];
  // Pointer lands one edge after the answer
  always @(posedge pclk) begin
    if (presetn && wb_en_r) begin
      wregs[wb_index_r] <= wb_value_r;
    end
  end
endmodule // work_register_model

// *** data_address_generator_properties.sv ***
// Port checker for the address generator
`timescale 1ns/100ps
`include "agen_defines.vh"
module agen_checker (
  // Clock, reset
  input wire pclk,
  input wire presetn,
  // Request
  input wire ce,
  input wire req_valid,
  input wire [1:0] req_class,
  input wire [2:0] req_mode,
  input wire [3:0] ptr_index,
  input wire [15:0] ptr_value,
  input wire [15:0] off_value,
  input wire [15:0] mod_amount,
  input wire [15:0] lit_raw,
  input wire [12:0] file_addr,
  // Answer
  input wire ea_valid_r,
  input wire [15:0] ea_r,
  input wire [1:0] ea_space_r,
  input wire ea_error_r,
  input wire wb_en_r,
  input wire [15:0] wb_value_r
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire go = ce && req_valid; // Taken this edge
  wire pf = go && ptr_index == 4'hF && !req_class[1]; // Pointer 15 never circular
  wire mac = go && req_class == `C_MAC;
  indirect_ea_a: assert property (pf && req_mode == `M_IND |=>
    ea_valid_r && ea_r == $past(ptr_value) && !wb_en_r) else $error("indirect EA");
  post_step_a: assert property (pf && req_mode == `M_POST |=> ea_r == $past(ptr_value)
    && wb_en_r && wb_value_r == $past(ptr_value) + $past(mod_amount)) else $error("post");
  pre_step_a: assert property (pf && req_mode == `M_PRE |=> wb_en_r && wb_value_r == ea_r
    && ea_r == $past(ptr_value) + $past(mod_amount)) else $error("pre");
  index_sum_a: assert property (pf && req_mode == `M_IDX |=> !wb_en_r
    && ea_r == $past(ptr_value) + $past(off_value)) else $error("indexed");
  literal_sum_a: assert property (pf && req_mode == `M_LOFF |=>
    ea_r == $past(ptr_value) + $past(lit_raw)) else $error("literal offset");
  file_near_a: assert property (go && req_class == `C_FILE && req_mode == `M_FILE |=>
    !ea_error_r && ea_r == {3'h0, $past(file_addr)}) else $error("file address");
  mac_range_a: assert property (mac && ptr_index[3:2] != 2'b10 |=>
    ea_error_r && !wb_en_r) else $error("MAC pointer");
  mac_index_a: assert property (mac && req_mode == `M_IDX && !ptr_index[0] |=>
    ea_error_r) else $error("MAC index");
  mac_space_a: assert property (mac && ptr_index[3:1] == 3'b101 && req_mode == `M_POST
    && mod_amount == 16'h0006 |=> ea_space_r == `S_Y && !ea_error_r) else $error("MAC space");
endmodule // agen_checker
bind data_address_generator agen_checker i_agen_checker (.*);

// *** data_address_generator_tb.sv ***
// Self-checking bench for the address generator
`timescale 1ns/100ps
`include "agen_defines.vh"
module data_address_generator_tb;
  reg pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, q;
  wire [31:0] prdata;
  wire pready, pslverr, ea_valid_r, ea_error_r, wb_en_r, res_to_file_r;
  reg req_valid = 0, to_default = 0, e;
  reg [1:0] req_class = 0, req_space = 0;
  reg [2:0] req_mode = 0, lit_kind = 0, m;
  reg [3:0] base_index = 0, ptr_index = 0, off_index = 0;
  reg [15:0] mod_amount = 0, lit_raw = 0, ov = 0, v, st, lt;
  reg [12:0] file_addr = 0;
  reg [16:0] x;
  wire [15:0] ptr_value, off_value, ea_r, wb_value_r, lit_value_r;
  wire [1:0] ea_space_r;
  wire [3:0] wb_index_r, src1_index_r, off_index_r, res_index_r;
  integer error_cnt = 0, check_count = 0, i;
  data_address_generator i_data_address_generator (.*);
  work_register_model i_work_register_model (.*);
  initial forever #4 pclk = ~pclk;
  // Hang guard
  initial begin
    #800000;
    error_cnt++;
    complete_run;
  end
  task complete_run;
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [32:0] got, input [32:0] exp);
    begin
      check_count++;
      if (got !== exp) begin
        error_cnt++;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; bounded wait on pready
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      for (n = 0; pready !== 1'b1; n++) begin
        if (n == 20) begin
          error_cnt++;
          complete_run;
        end
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // Request; spacer edge keeps write-back clear of the next load
  task fire(input [1:0] c, input [2:0] md, input [1:0] s, input [3:0] p, input [15:0] pv,
    input [15:0] sp, input [15:0] li);
    begin
      repeat (2) @(posedge pclk);
      i_work_register_model.wregs[p ^ 4'h8] <= ov;
      i_work_register_model.wregs[p] <= pv;
      req_class <= c;
      req_mode <= md;
      req_space <= s;
      ptr_index <= p;
      off_index <= p ^ 4'h8;
      base_index <= p + 4'h1;
      mod_amount <= sp;
      lit_raw <= li;
      req_valid <= 1;
      @(posedge pclk);
      req_valid <= 0;
      #1;
      check(ea_valid_r, 1);
      check(src1_index_r, base_index);
      check(off_index_r, off_index);
    end
  endtask
  task req(input [1:0] c, input [2:0] md, input [1:0] s, input [3:0] p, input [15:0] pv,
    input [15:0] sp, input [15:0] li, input [15:0] ea, input w, input [15:0] wv, input er);
    begin
      fire(c, md, s, p, pv, sp, li);
      check(ea_error_r, er);
      check(wb_en_r, w);
      if (!er) check(ea_r, ea);
      if (w) check({wb_index_r, wb_value_r}, {p, wv});
    end
  endtask
  function [16:0] exp_ea(input [2:0] md, input [15:0] pv, sp, li);
    case (md)
      `M_PRE: exp_ea = {1'b1, pv + sp};
      `M_IDX: exp_ea = {1'b0, pv + ov};
      `M_LOFF: exp_ea = {1'b0, pv + li};
      default: exp_ea = {md == `M_POST, pv};
    endcase
  endfunction
  function [15:0] lmask(input [2:0] k);
    case (k)
      `L_5: lmask = 16'h001F;
      `L_8: lmask = 16'h00FF;
      `L_10: lmask = 16'h03FF;
      `L_HOLD: lmask = 16'h3FFF;
      default: lmask = 16'hFFFF;
    endcase
  endfunction
  initial begin
    x = $urandom(30682);
    repeat (8) @(posedge pclk);
    presetn <= 1;
    // Reset values, readback, unmapped place
    for (i = 0; i < 5; i++) begin
      apb(0, i * 4, 0);
      check(q, i == 0 ? 32'h00FF : 0);
      v = $urandom;
      apb(1, i * 4, v);
      apb(0, i * 4, 0);
      check({e, q}, {17'h0, v});
    end
    apb(1, 12'h018, 32'h1234);
    apb(0, 12'h018, 0);
    check({e, q}, 33'h100000000);
    apb(1, `OFF_CTRL, 32'h00FF);
    // Random move-class traffic, circular off
    for (i = 0; i < 40; i++) begin
      m = 3'h2 + $urandom % 5;
      v = $urandom;
      st = $urandom % 16 - 8;
      lt = $urandom;
      ov = $urandom;
      x = exp_ea(m, v, st, lt);
      req(`C_MOVE, m, $urandom % 3, $urandom, v, st, lt, x, x[16], v + st, 0);
    end
    for (i = 0; i < 6; i++) begin
      @(posedge pclk);
      lit_kind <= i;
      fire(`C_MCU, `M_DIR, 0, 1, 0, 0, 16'hBEEF);
      check(lit_value_r, 16'hBEEF & lmask(i));
    end
    @(posedge pclk);
    file_addr <= 13'h1ABC;
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      to_default <= i;
      fire(`C_FILE, `M_FILE, 0, 6, 0, 0, 0);
      check({res_to_file_r, res_index_r, ea_r}, {i == 0, 20'h01ABC});
    end
    // Refused combinations, then legal dual-operand fetches
    req(`C_MCU, `M_IDX, 0, 2, 0, 0, 0, 0, 0, 0, 1);
    req(`C_MAC, `M_IND, 0, 7, 0, 0, 0, 0, 0, 0, 1);
    req(`C_MAC, `M_POST, 0, 8, 0, 3, 0, 0, 0, 0, 1);
    req(`C_MAC, `M_IDX, 0, 8, 0, 0, 0, 0, 0, 0, 1);
    req(`C_MAC, `M_PRE, 0, 9, 0, 2, 0, 0, 0, 0, 1);
    // Status: last address 2, error bit set, nothing armed
    apb(0, `OFF_STAT, 0);
    check({e, q}, 33'h000020004);
    ov = 16'h0010;
    req(`C_MAC, `M_IDX, 2, 9, 16'h0100, 0, 0, 16'h0110, 0, 0, 0);
    check(ea_space_r, `S_XRD);
    req(`C_MAC, `M_POST, 0, 10, 16'h0800, 6, 0, 16'h0800, 1, 16'h0806, 0);
    // X buffer on pointer 3, 32 bytes; pointer choice keeps off the stack pair
    apb(1, `OFF_CTRL, 32'h80F3);
    apb(1, `OFF_XSRT, 32'h1000);
    apb(1, `OFF_XEND, 32'h101F);
    req(`C_MCU, `M_POST, 0, 3, 16'h101E, 4, 0, 16'h101E, 1, 16'h1002, 0);
    req(`C_MCU, `M_PRE, 1, 3, 16'h1000, 16'hFFFC, 0, 16'h101C, 1, 16'h101C, 0);
    ov = 16'h0014;
    req(`C_MOVE, `M_IDX, 0, 3, 16'h1010, 0, 0, 16'h1004, 0, 0, 0);
    req(`C_MCU, `M_POST, 0, 4, 16'h101E, 4, 0, 16'h101E, 1, 16'h1022, 0);
    apb(1, `OFF_CTRL, 32'h00F3);
    req(`C_MCU, `M_POST, 0, 3, 16'h101E, 4, 0, 16'h101E, 1, 16'h1022, 0);
    apb(1, `OFF_CTRL, 32'h80FF);
    req(`C_MCU, `M_POST, 0, 15, 16'h101E, 4, 0, 16'h101E, 1, 16'h1022, 0);
    // Y buffer on pointer 5, 64 bytes
    apb(1, `OFF_CTRL, 32'h405F);
    apb(1, `OFF_YSRT, 32'h2000);
    apb(1, `OFF_YEND, 32'h203F);
    req(`C_MCU, `M_PRE, 2, 5, 16'h203E, 4, 0, 16'h2002, 1, 16'h2002, 0);
    req(`C_MCU, `M_IND, 2, 5, 16'h2011, 0, 0, 16'h2010, 0, 0, 0);
    req(`C_MCU, `M_PRE, 0, 5, 16'h203E, 4, 0, 16'h2042, 1, 16'h2042, 0);
    // Status: last address, Y armed only
    apb(0, `OFF_STAT, 0);
    check({e, q}, 33'h020420002);
    // Clock enable low: the request waits until it rises
    @(posedge pclk);
    ce <= 0;
    req_valid <= 1;
    repeat (2) @(posedge pclk);
    ce <= 1;
    #1;
    check(ea_valid_r, 0);
    @(posedge pclk);
    req_valid <= 0;
    #1;
    check(ea_valid_r, 1);
    complete_run;
  end
endmodule // data_address_generator_tb
